// ===== lsl_far_end.sv
// Far-end LVDS partner: drives the receive pair, watches the transmit pair.
// Assumes the bench clock mclk and bench control of its inputs.
`timescale 1ns/1ps
`default_nettype none
module lsl_far_end (
   // Clock
   input  wire logic mclk,
   // Line toward the lane
   input  wire logic driveOn,
   input  wire logic lineLevel,
   output logic      rxPadP,
   output logic      rxPadN,
   // Line from the lane
   input  wire logic txPadP,
   input  wire logic txPadN,
   input  wire logic txPadOe,
   input  wire logic countOn,
   output int        highCount,
   output int        edgeCount,
   output int        badCount
);
   logic idleBit = 1'b0;
   logic lastP   = 1'b0;
   assign rxPadP = driveOn ? lineLevel : idleBit;
   assign rxPadN = ~rxPadP;
   // Undriven line wanders
   always @(posedge mclk) idleBit <= ~idleBit;
   // Counts only while the lane drives
   always @(posedge mclk) begin
      lastP <= txPadP;
      if (!countOn) begin
         highCount <= 0;
         edgeCount <= 0;
         badCount  <= 0;
      end else if (txPadOe) begin
         highCount <= highCount + int'(txPadP);
         edgeCount <= edgeCount + int'(txPadP != lastP);
         badCount  <= badCount + int'(txPadP == txPadN);
      end
   end
endmodule // lsl_far_end
`default_nettype wire

// ===== lsl_pkg.sv
// Constants for the LVDS lane: register map, fields, widths.
// Assumes a 32-bit APB master and a single 25 MHz clock.
package lsl_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int WORD_W   = 10;
   localparam int TAP_W    = 3;
   localparam int DLY_LEN  = 8;
   localparam int FIFO_DEP = 8;
   localparam int PTR_W    = 4;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DELAY  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RXDATA = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h10;

   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   localparam int CTL_MODE   = 0;
   localparam int CTL_HALF   = 2;
   localparam int CTL_FIFO   = 3;
   localparam int CTL_ALIGN  = 4;
   localparam int CTL_TDYN   = 5;
   localparam int CTL_TERM   = 6;
   localparam int CTL_IBUF   = 7;
   localparam int CTL_ALT    = 8;
   localparam int CTL_OE     = 9;
   localparam int CTL_CLKOUT = 10;
   localparam int CTL_RXRST  = 11;
   localparam int CTL_TXRST  = 12;
   localparam int CTL_WIDTH  = 16;
   localparam logic [DATA_W-1:0] CTRL_RST  = 32'h000A_0000;
   localparam logic [DATA_W-1:0] CTRL_MASK = 32'h000F_1FFF;

   localparam logic [1:0] MODE_RX    = 2'h0;
   localparam logic [1:0] MODE_TX    = 2'h1;
   localparam logic [1:0] MODE_BIDIR = 2'h2;

   // Delay control fields
   localparam int DLY_EN  = 0;
   localparam int DLY_DIR = 1;
   localparam int DLY_CLR = 2;

   // Alignment training
   localparam logic [WORD_W-1:0] ALIGN_PATTERN = 10'h1F0;
   localparam logic [3:0]        LOCK_WORDS    = 4'h4;
   localparam logic [3:0]        WIDTH_MAX     = 4'hA;
   localparam logic [TAP_W-1:0]  TAP_MAX       = 3'h7;

   typedef enum logic [1:0] {ALN_IDLE, ALN_SEARCH, ALN_LOCKED} lsl_align_t;

endpackage

// ===== lsl_serdes_lane.sv
// LVDS lane: deserializer, serializer, delay/alignment, RX FIFO, APB.
// Assumes one clock mclk; pad inputs are asynchronous to it.
// Contract
// - Lane works as receive, transmit or both over one pad pair.
// - Serial word width programmable up to ten bits each way.
// - Full rate: one bit per fast clock, on its rising edge.
// - Half rate: fast clock at half bit rate, bits on both edges.
// - Optional eight-word receive FIFO toward the reader.
// - FIFO empty flag high while FIFO holds no word.
// - Receive reset clears FIFO and deserializer.
// - Phase alignment moves delay to bit centre, full rate only.
// - Lock output high once alignment training has locked.
// - With enable, direction 1 increments and 0 decrements delay.
// - Delay clear resets delay counter or alignment circuit.
// - Input buffer enable turns the receiver on or off.
// - Dynamic termination mode: control bit switches termination.
// - Alternate clock tap only in bypass, width one.
// - Each aligned received word presented on slow clock edge.
// - Transmit reset clears the serializer.
// - Output enable controls whether the pad pair is driven.
// - Transmit lane sends serial data or a reference clock.
`timescale 1ns/1ps
`default_nettype none

module lsl_serdes_lane (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Differential pads
   input  wire logic        rxPadP,
   input  wire logic        rxPadN,
   output logic             txPadP,
   output logic             txPadN,
   output logic             txPadOe,
   // Pad controls and status
   output logic             inputBufferOn,
   output logic             termEnable,
   output logic             alternateClockTap,
   output logic             serialBitClock,
   output logic             parallelWordClock,
   output logic             alignLock,
   output logic             fifoEmpty
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [31:0] ctrl_r;
   logic [1:0]  delayCtl_r;
   logic [31:0] prdata_r;
   logic        popArm_r;
   logic [31:0] readMux;
   logic        setup, access, wrEn, mapped, dlyClear, rdPop;
   logic [1:0]  laneMode;
   logic        halfRate, fifoOn, autoAlign, altSel, clockOut;
   logic        rxReset, txReset, rxActive, txActive, alignActive;
   logic [3:0]  widthRaw, wordWidth;
   logic [9:0]  wordMask;
   logic        fastPhase_r, bitTick, wordTick;
   logic [3:0]  bitCnt_r;
   logic [1:0]  padSync1_r, padSync2_r;
   logic [7:0]  dlyLine_r;
   logic        sampledBit;
   logic [9:0]  rxShift_r, rxAsm, rxWord_r;
   logic        wordMatch;
   logic [9:0]  fifoMem [lsl_pkg::FIFO_DEP];
   logic [3:0]  wrPtr_r, rdPtr_r;
   logic        fifoFull, push;
   logic [2:0]  tap_r;
   logic [3:0]  matchCnt_r;
   lsl_pkg::lsl_align_t alignState_r;
   logic [9:0]  txWord_r, txCur_r;
   logic        txBit, txPadP_r, txPadN_r, txPadOe_r;
   logic        altTap_r, wordClk_r, termEn_r;

   // ---------------------------------------------------------------
   // Configuration decode
   // ---------------------------------------------------------------
   assign laneMode  = ctrl_r[lsl_pkg::CTL_MODE +: 2];
   assign halfRate  = ctrl_r[lsl_pkg::CTL_HALF];
   assign fifoOn    = ctrl_r[lsl_pkg::CTL_FIFO];
   assign autoAlign = ctrl_r[lsl_pkg::CTL_ALIGN];
   assign altSel    = ctrl_r[lsl_pkg::CTL_ALT];
   assign clockOut  = ctrl_r[lsl_pkg::CTL_CLKOUT];
   assign rxReset   = ctrl_r[lsl_pkg::CTL_RXRST];
   assign txReset   = ctrl_r[lsl_pkg::CTL_TXRST];
   assign widthRaw  = ctrl_r[lsl_pkg::CTL_WIDTH +: 4];
   assign wordWidth = (widthRaw == 4'h0) ? 4'h1 :
                      (widthRaw > lsl_pkg::WIDTH_MAX) ? lsl_pkg::WIDTH_MAX
                      : widthRaw;
   assign wordMask  = 10'h3FF >> (lsl_pkg::WIDTH_MAX - wordWidth);
   assign rxActive  = (laneMode != lsl_pkg::MODE_TX) && !rxReset;
   assign txActive  = (laneMode != lsl_pkg::MODE_RX) && !txReset;
   assign alignActive = autoAlign && !halfRate;

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   assign setup    = psel && !penable;
   assign access   = psel && penable;
   assign pready   = access;
   assign wrEn     = access && pwrite;
   assign mapped   = (paddr == lsl_pkg::OFS_CTRL)   ||
                     (paddr == lsl_pkg::OFS_DELAY)  ||
                     (paddr == lsl_pkg::OFS_STATUS) ||
                     (paddr == lsl_pkg::OFS_RXDATA) ||
                     (paddr == lsl_pkg::OFS_TXDATA);
   assign pslverr  = access && !mapped;
   assign prdata   = prdata_r;
   assign dlyClear = wrEn && (paddr == lsl_pkg::OFS_DELAY) &&
                     pwdata[lsl_pkg::DLY_CLR];
   // Read of RXDATA is the FIFO read strobe
   assign rdPop    = access && !pwrite && popArm_r && !fifoEmpty;

   always_comb begin
      readMux = 32'h0000_0000;
      if (paddr == lsl_pkg::OFS_CTRL) begin
         readMux = ctrl_r;
      end else if (paddr == lsl_pkg::OFS_DELAY) begin
         readMux = {30'h0, delayCtl_r};
      end else if (paddr == lsl_pkg::OFS_STATUS) begin
         readMux = {25'h0, tap_r, 1'b0, fifoFull, fifoEmpty, alignLock};
      end else if (paddr == lsl_pkg::OFS_RXDATA) begin
         if (!fifoOn) begin
            readMux = {22'h0, rxWord_r};
         end else if (!fifoEmpty) begin
            readMux = {22'h0, fifoMem[rdPtr_r[2:0]]};
         end
      end else if (paddr == lsl_pkg::OFS_TXDATA) begin
         readMux = {22'h0, txWord_r};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prdata_r <= 32'h0000_0000;
         popArm_r <= 1'b0;
      end else if (setup) begin
         prdata_r <= pwrite ? 32'h0000_0000 : readMux;
         popArm_r <= !pwrite && fifoOn && !fifoEmpty &&
                     (paddr == lsl_pkg::OFS_RXDATA);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_r     <= lsl_pkg::CTRL_RST;
         delayCtl_r <= 2'h0;
         txWord_r   <= 10'h000;
      end else if (wrEn) begin
         if (paddr == lsl_pkg::OFS_CTRL) begin
            ctrl_r <= pwdata & lsl_pkg::CTRL_MASK;
         end else if (paddr == lsl_pkg::OFS_DELAY) begin
            delayCtl_r <= pwdata[1:0];
         end else if (paddr == lsl_pkg::OFS_TXDATA) begin
            txWord_r <= pwdata[9:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Bit and word timing
   // ---------------------------------------------------------------
   // Full rate: bits on rising phase only
   // Half rate: bits on both phases
   assign bitTick  = halfRate ? 1'b1 : fastPhase_r;
   // Word rate is bit rate over width
   assign wordTick = bitTick && (bitCnt_r == wordWidth - 4'h1);
   assign serialBitClock    = fastPhase_r;
   assign parallelWordClock = wordClk_r;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fastPhase_r <= 1'b0;
         bitCnt_r    <= 4'h0;
         wordClk_r   <= 1'b0;
      end else begin
         fastPhase_r <= !fastPhase_r;
         wordClk_r   <= (bitCnt_r < (wordWidth >> 1));
         if (wordTick || bitCnt_r >= wordWidth) begin
            bitCnt_r <= 4'h0;
         end else if (bitTick) begin
            bitCnt_r <= bitCnt_r + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pad input, delay line
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         padSync1_r <= 2'h0;
         padSync2_r <= 2'h0;
         dlyLine_r  <= 8'h00;
      end else begin
         padSync1_r <= {rxPadN, rxPadP};
         padSync2_r <= padSync1_r;
         dlyLine_r  <= {dlyLine_r[6:0], padSync2_r[0] && !padSync2_r[1]};
      end
   end

   // Buffer off forces the received bit low
   assign sampledBit = inputBufferOn && dlyLine_r[tap_r];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         termEn_r <= 1'b0;
         altTap_r <= 1'b0;
      end else begin
         termEn_r <= ctrl_r[lsl_pkg::CTL_TDYN] && ctrl_r[lsl_pkg::CTL_TERM];
         altTap_r <= (wordWidth == 4'h1) && altSel && rxActive && sampledBit;
      end
   end
   assign inputBufferOn     = ctrl_r[lsl_pkg::CTL_IBUF];
   assign termEnable        = termEn_r;
   assign alternateClockTap = altTap_r;

   // ---------------------------------------------------------------
   // Deserializer
   // ---------------------------------------------------------------
   always_comb begin
      rxAsm = rxShift_r;
      rxAsm[bitCnt_r] = sampledBit;
   end
   assign wordMatch = (rxAsm & wordMask) == (lsl_pkg::ALIGN_PATTERN & wordMask);

   always_ff @(posedge mclk) begin
      if (!rst_n || !rxActive) begin
         rxShift_r <= 10'h000;
         rxWord_r  <= 10'h000;
      end else if (wordTick) begin
         rxShift_r <= 10'h000;
         // Word presented at word boundary, masked
         rxWord_r  <= rxAsm & wordMask;
      end else if (bitTick) begin
         rxShift_r <= rxAsm;
      end
   end

   // ---------------------------------------------------------------
   // Receive FIFO
   // ---------------------------------------------------------------
   // Empty when pointers meet
   assign fifoEmpty = (wrPtr_r == rdPtr_r);
   assign fifoFull  = (wrPtr_r[3] != rdPtr_r[3]) &&
                      (wrPtr_r[2:0] == rdPtr_r[2:0]);
   assign push      = wordTick && rxActive && fifoOn && !fifoFull;

   always_ff @(posedge mclk) begin
      if (push) begin
         fifoMem[wrPtr_r[2:0]] <= rxAsm & wordMask;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || rxReset) begin
         wrPtr_r <= 4'h0;
         rdPtr_r <= 4'h0;
      end else begin
         if (push) begin
            wrPtr_r <= wrPtr_r + 4'h1;
         end
         if (rdPop) begin
            rdPtr_r <= rdPtr_r + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Delay control and phase alignment
   // ---------------------------------------------------------------
   assign alignLock = (alignState_r == lsl_pkg::ALN_LOCKED);

   always_ff @(posedge mclk) begin
      if (!rst_n || dlyClear) begin
         tap_r        <= 3'h0;
         matchCnt_r   <= 4'h0;
         alignState_r <= lsl_pkg::ALN_IDLE;
      end else if (!alignActive) begin
         alignState_r <= lsl_pkg::ALN_IDLE;
         matchCnt_r   <= 4'h0;
         if (delayCtl_r[lsl_pkg::DLY_EN] && wordTick) begin
            if (delayCtl_r[lsl_pkg::DLY_DIR] && tap_r != lsl_pkg::TAP_MAX) begin
               tap_r <= tap_r + 3'h1;
            end else if (!delayCtl_r[lsl_pkg::DLY_DIR] && tap_r != 3'h0) begin
               tap_r <= tap_r - 3'h1;
            end
         end
      end else begin
         // Search tap until training word holds
         case (alignState_r)
            lsl_pkg::ALN_IDLE: begin
               if (delayCtl_r[lsl_pkg::DLY_EN]) begin
                  alignState_r <= lsl_pkg::ALN_SEARCH;
               end
            end
            lsl_pkg::ALN_SEARCH: begin
               if (!delayCtl_r[lsl_pkg::DLY_EN]) begin
                  alignState_r <= lsl_pkg::ALN_IDLE;
               end else if (wordTick && wordMatch) begin
                  matchCnt_r <= matchCnt_r + 4'h1;
                  if (matchCnt_r == lsl_pkg::LOCK_WORDS - 4'h1) begin
                     alignState_r <= lsl_pkg::ALN_LOCKED;
                  end
               end else if (wordTick) begin
                  matchCnt_r <= 4'h0;
                  tap_r      <= tap_r + 3'h1;
               end
            end
            lsl_pkg::ALN_LOCKED: begin
               if (wordTick && !wordMatch) begin
                  alignState_r <= lsl_pkg::ALN_SEARCH;
                  matchCnt_r   <= 4'h0;
               end
            end
            default: alignState_r <= lsl_pkg::ALN_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Serializer
   // ---------------------------------------------------------------
   // Data or reference clock pattern
   assign txBit = clockOut ? (bitCnt_r < (wordWidth >> 1)) : txCur_r[bitCnt_r];

   always_ff @(posedge mclk) begin
      if (!rst_n || !txActive) begin
         txCur_r  <= 10'h000;
         txPadP_r <= 1'b0;
         txPadN_r <= 1'b1;
      end else begin
         // Word taken at word boundary, masked
         if (wordTick) begin
            txCur_r <= txWord_r & wordMask;
         end
         if (bitTick) begin
            txPadP_r <= txBit;
            txPadN_r <= !txBit;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         txPadOe_r <= 1'b0;
      end else begin
         txPadOe_r <= txActive && ctrl_r[lsl_pkg::CTL_OE];
      end
   end
   assign txPadP  = txPadP_r;
   assign txPadN  = txPadN_r;
   assign txPadOe = txPadOe_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence manualStep;
      !alignActive && delayCtl_r[lsl_pkg::DLY_EN] && wordTick && !dlyClear;
   endsequence

   sequence goodWord;
      alignActive && wordTick && wordMatch && !dlyClear;
   endsequence

   rx_only_oe_a: assert property (
      laneMode == lsl_pkg::MODE_RX |=> !txPadOe)
      else $error("pad driven in receive-only mode");
   rx_word_mask_a: assert property (
      wordTick |=> (rxWord_r & ~$past(wordMask)) == 10'h000)
      else $error("unused receive bits not zero");
   full_rate_a: assert property (
      (!halfRate && bitTick) ##1 !halfRate |-> !bitTick)
      else $error("two bits in a row at full rate");
   half_rate_a: assert property (
      halfRate && $past(halfRate) |-> bitTick ##1 (!halfRate || bitTick))
      else $error("bit missed at half rate");
   rx_word_a: assert property (
      wordTick && rxActive ##1 rxActive |-> rxWord_r == $past(rxAsm & wordMask))
      else $error("received word not presented");
   fifo_fill_a: assert property (
      push && fifoEmpty && !rxReset |=> !fifoEmpty)
      else $error("empty flag stuck after push");
   rx_reset_a: assert property (
      rxReset |=> fifoEmpty && rxWord_r == 10'h000)
      else $error("receive reset left data");
   align_half_a: assert property (
      halfRate |=> !alignLock)
      else $error("lock in half-rate mode");
   lock_cause_a: assert property (
      goodWord [*1] ##0 (matchCnt_r == lsl_pkg::LOCK_WORDS - 4'h1) |=> alignLock)
      else $error("lock not reached after training");
   tap_up_a: assert property (
      manualStep ##0 (delayCtl_r[lsl_pkg::DLY_DIR] && tap_r != lsl_pkg::TAP_MAX)
      |=> tap_r == $past(tap_r) + 3'h1)
      else $error("delay did not increment");
   tap_down_a: assert property (
      manualStep ##0 (!delayCtl_r[lsl_pkg::DLY_DIR] && tap_r != 3'h0)
      |=> tap_r == $past(tap_r) - 3'h1)
      else $error("delay did not decrement");
   delay_clear_a: assert property (
      dlyClear |=> tap_r == 3'h0 && !alignLock)
      else $error("delay clear ignored");
   alt_bypass_a: assert property (
      alternateClockTap |-> $past(wordWidth == 4'h1 && altSel))
      else $error("alternate tap outside bypass");
   tx_reset_a: assert property (
      txReset |=> !txPadP && txPadN)
      else $error("serializer not reset");

endmodule // lsl_serdes_lane

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the LVDS lane through its APB registers.
// Assumes lsl_pkg, lsl_serdes_lane and lsl_far_end compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [7:0] CTL = lsl_pkg::OFS_CTRL;
   localparam logic [7:0] DLY = lsl_pkg::OFS_DELAY;
   localparam logic [7:0] STA = lsl_pkg::OFS_STATUS;
   localparam logic [7:0] RXD = lsl_pkg::OFS_RXDATA;
   logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, driveOn = 1'b0, countOn = 1'b0, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic        pready, pslverr, rxPadP, rxPadN, txPadP, txPadN, txPadOe;
   logic        inputBufferOn, termEnable, alternateClockTap;
   logic        alignLock, fifoEmpty, wordClk, bitClk, lineLevel;
   logic        patOn = 1'b0;
   int          highCount, edgeCount, badCount;
   int          mismatches = 0;
   int          cmp_count = 0;

   always #20 mclk = ~mclk;

   // word clock paces the training pattern
   assign lineLevel = patOn ? wordClk : 1'b1;

   lsl_serdes_lane uut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPadP(rxPadP),
      .rxPadN(rxPadN), .txPadP(txPadP), .txPadN(txPadN), .txPadOe(txPadOe),
      .inputBufferOn(inputBufferOn), .termEnable(termEnable),
      .alternateClockTap(alternateClockTap), .serialBitClock(bitClk),
      .parallelWordClock(wordClk), .alignLock(alignLock),
      .fifoEmpty(fifoEmpty));
   lsl_far_end far (.mclk(mclk), .driveOn(driveOn), .lineLevel(lineLevel),
      .rxPadP(rxPadP), .rxPadN(rxPadN), .txPadP(txPadP), .txPadN(txPadN),
      .txPadOe(txPadOe), .countOn(countOn), .highCount(highCount),
      .edgeCount(edgeCount), .badCount(badCount));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
      apb(1'b1, a, d);
      idle(n);
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0000_0000);
      chk(q & m, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rdm(a, 32'hFFFF_FFFF, e);
   endtask

   task automatic t_reset;
      rd(CTL, 32'h000A_0000);
      rd(STA, 32'h0000_0002);
      chk(32'({txPadP, txPadN, txPadOe, termEnable}), 32'h0000_0004);
      rd(8'h40, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      wr(CTL, 32'h000A_00E0, 2);
      chk(32'({inputBufferOn, termEnable}), 32'h0000_0003);
      wr(CTL, 32'h000A_0040, 2);
      chk(32'({inputBufferOn, termEnable}), 32'h0000_0000);
      $display("test reset and pads done");
   endtask
   task automatic t_rx;
      driveOn <= 1'b1;
      wr(CTL, 32'h0004_0080, 100);
      rd(RXD, 32'h0000_000F);
      wr(CTL, 32'h000A_0080, 100);
      rd(RXD, 32'h0000_03FF);
      wr(CTL, 32'h000A_0000, 100);
      rd(RXD, 32'h0000_0000);
      wr(CTL, 32'h0001_0180, 20);
      chk(32'(alternateClockTap), 32'h0000_0001);
      wr(CTL, 32'h0004_0180, 20);
      chk(32'(alternateClockTap), 32'h0000_0000);
      q[0] = bitClk;
      @(posedge mclk);
      chk(32'(bitClk), 32'(!q[0]));
      $display("test receive done");
   endtask
   task automatic t_fifo;
      wr(CTL, 32'h000A_0088, 300);
      rd(STA, 32'h0000_0004);
      wr(CTL, 32'h000A_0089, 0);
      repeat (8) rd(RXD, 32'h0000_03FF);
      idle(1);
      chk(32'(fifoEmpty), 32'h0000_0001);
      rd(RXD, 32'h0000_0000);
      wr(CTL, 32'h000A_0088, 100);
      chk(32'(fifoEmpty), 32'h0000_0000);
      wr(CTL, 32'h000A_0888, 2);
      chk(32'(fifoEmpty), 32'h0000_0001);
      $display("test fifo done");
   endtask
   task automatic t_delay;
      wr(CTL, 32'h000A_0080, 0);
      wr(DLY, 32'h0000_0003, 400);
      rdm(STA, 32'h0000_0070, 32'h0000_0070);
      wr(DLY, 32'h0000_0004, 2);
      rdm(STA, 32'h0000_0070, 32'h0000_0000);
      wr(DLY, 32'h0000_0001, 100);
      rdm(STA, 32'h0000_0070, 32'h0000_0000);
      wr(CTL, 32'h000A_0094, 0);
      wr(DLY, 32'h0000_0003, 400);
      rdm(STA, 32'h0000_0071, 32'h0000_0070);
      wr(CTL, 32'h000A_0090, 0);
      wr(DLY, 32'h0000_0001, 400);
      chk(32'(alignLock), 32'h0000_0000);
      patOn <= 1'b1;
      idle(400);
      chk(32'(alignLock), 32'h0000_0001);
      wr(DLY, 32'h0000_0004, 2);
      chk(32'(alignLock), 32'h0000_0000);
      patOn <= 1'b0;
      wr(DLY, 32'h0000_0000, 0);
      $display("test delay done");
   endtask
   task automatic t_tx;
      logic [31:0] ctl [0:6] = '{32'h0004_0201, 32'h0004_0205, 32'h0004_0601,
         32'h0004_0001, 32'h0004_1201, 32'h0004_0200, 32'h0004_0202};
      int hi [0:6] = '{40, 40, 40, 0, 0, 0, 40};
      int ed [0:6] = '{40, 80, 20, 0, 0, 0, 40};
      wr(lsl_pkg::OFS_TXDATA, 32'h0000_03F5, 0);
      for (int i = 0; i < 7; i++) begin
         wr(CTL, ctl[i], 40);
         countOn <= 1'b1;
         idle(80);
         countOn <= 1'b0;
         idle(1);
         chk(32'(highCount), 32'(hi[i]));
         chk(32'(edgeCount), 32'(ed[i]));
         chk(32'(badCount), 32'h0000_0000);
      end
      $display("test transmit done");
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      idle(10);
      rst_n <= 1'b1;
      t_reset;
      t_rx;
      t_fifo;
      t_delay;
      t_tx;
      tally_and_finish;
   end
   initial begin
      idle(20000);
      mismatches++;
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire
